// ### src/iomx_regs.vh
// Constants for the increment, OR, move and pointer-load execute block.
// What this block does
// - Destination bit clear: result goes to working register, file untouched.
// - Destination bit set: result written back to the addressed file register.
// - Bank bit clear: operand addressed in the fixed access bank.
// - Bank bit set: address is low four bits of bank select register joined with operand.
// - Increment file adds one, updates carry, digit carry, negative, overflow, zero.
// - Increment skip if zero: zero result discards next word, two cycles.
// - Increment skip if nonzero: nonzero result discards next fetched word.
// - Skip over a two-word instruction takes three cycles in total.
// - Increment-and-skip instructions leave every status flag unchanged.
// - OR instruction ORs working register with file register into destination.
// - OR updates only negative and zero flags.
// - Pointer load puts a 12-bit literal into one of three pointers, flags kept.
// - Pointer load: two words, two cycles, high four bits first then low byte.
// - Move file copies file register to destination, updates negative and zero.
// - Move operand reaches any location of the 256-byte bank.
`ifndef IOMX_REGS_VH
`define IOMX_REGS_VH
`define IOMX_OP_HI_OR      4'h1
`define IOMX_OP_HI_INC     4'h2
`define IOMX_OP_HI_INSNZ   4'h4
`define IOMX_OP_HI_MOV     4'h5
`define IOMX_OP_HI_INSZ    4'h3
`define IOMX_OP_HI_LONG    4'hE
`define IOMX_OP_HI_EXT     4'hF
`define IOMX_SUB_INC       2'b10
`define IOMX_SUB_OR        2'b00
`define IOMX_SUB_PTR       4'hE
`define IOMX_BIT_D         9
`define IOMX_BIT_A         8
`define IOMX_ACCESS_BANK   4'h0
`define IOMX_PTR_COUNT     3
`define IOMX_FLAG_C        0
`define IOMX_FLAG_DC       1
`define IOMX_FLAG_Z        2
`define IOMX_FLAG_OV       3
`define IOMX_FLAG_N        4
`define IOMX_STATUS_RESET  5'h00
`endif

// ### src/iomx_twoword_detect.v
// Recognition of the first word of a two-word instruction.
`timescale 1ns/1ps
`include "iomx_regs.vh"
module iomx_twoword_detect (
  instr_word,
  is_two_word
);
  input  wire [15:0] instr_word;
  output wire        is_two_word;

  // Long branches and calls, and the pointer load, take a second word.
  assign is_two_word = (instr_word[15:12] == `IOMX_OP_HI_LONG) &&
                       ((instr_word[11:8] == `IOMX_SUB_PTR) ||
                        (instr_word[11:8] == 4'hC) || (instr_word[11:9] == 3'b111));
endmodule // iomx_twoword_detect

// ### src/iomx_execute.v
// Execute unit for increment, skip, OR, move and pointer-load instructions.
`timescale 1ns/1ps
`include "iomx_regs.vh"
module iomx_execute #(
  parameter PTR_W = 12
) (
  clk,
  resetn,
  instr_valid,
  instr_word,
  bank_select_register,
  file_rdata,
  file_addr,
  file_wdata,
  file_we,
  working_register,
  status_flags,
  ptr0_ff_out,
  ptr1_ff_out,
  ptr2_ff_out,
  phase,
  instr_taken,
  skip_active,
  exec_busy
);
  input  wire             clk;
  input  wire             resetn;
  input  wire             instr_valid;
  input  wire [15:0]      instr_word;
  input  wire [7:0]       bank_select_register;
  input  wire [7:0]       file_rdata;
  output reg  [11:0]      file_addr;
  output reg  [7:0]       file_wdata;
  output reg              file_we;
  output wire [7:0]       working_register;
  output wire [4:0]       status_flags;
  output wire [PTR_W-1:0] ptr0_ff_out;
  output wire [PTR_W-1:0] ptr1_ff_out;
  output wire [PTR_W-1:0] ptr2_ff_out;
  output wire [1:0]       phase;
  output wire             instr_taken;
  output wire             skip_active;
  output wire             exec_busy;

  // Per-instruction states.
  localparam ST_IDLE  = 2'd0;
  localparam ST_EXEC  = 2'd1;
  localparam ST_PTRLO = 2'd2;
  localparam ST_SKIP  = 2'd3;
  localparam PH_DEC   = 2'd0;
  localparam PH_READ  = 2'd1;
  localparam PH_PROC  = 2'd2;
  localparam PH_WRITE = 2'd3;

  reg  [1:0]       state_ff;
  reg  [1:0]       phase_ff;
  reg  [15:0]      instr_ff;
  reg  [7:0]       oper_ff;
  reg  [7:0]       result_ff;
  reg  [7:0]       working_register_ff;
  reg  [4:0]       flags_ff;
  reg  [3:0]       ptr_hi_ff;
  reg  [1:0]       ptr_sel_ff;
  reg              skip_ff;
  reg              skip2_ff;
  reg  [PTR_W-1:0] ptr_ff [0:`IOMX_PTR_COUNT-1];
  wire             two_word;
  wire [3:0]       op_hi;
  wire [1:0]       op_sub;
  wire             is_inc;
  wire             is_insz;
  wire             is_insnz;
  wire             is_or;
  wire             is_mov;
  wire             is_ptr;
  wire             dest_file;
  wire [8:0]       inc_sum;
  wire [1:0]       ptr_sel_now;
  reg  [7:0]       nxt_result;
  reg  [4:0]       nxt_flags;
  reg              nxt_skip;

  iomx_twoword_detect u_twoword (
    .instr_word  (instr_word),
    .is_two_word (two_word)
  );

  assign op_hi     = instr_ff[15:12];
  assign op_sub    = instr_ff[11:10];
  assign is_inc    = (op_hi == `IOMX_OP_HI_INC) && (op_sub == `IOMX_SUB_INC);
  assign is_insz   = (op_hi == `IOMX_OP_HI_INSZ) && (op_sub == 2'b11);
  assign is_insnz  = (op_hi == `IOMX_OP_HI_INSNZ) && (op_sub == `IOMX_SUB_INC);
  assign is_or     = (op_hi == `IOMX_OP_HI_OR) && (op_sub == `IOMX_SUB_OR);
  assign is_mov    = (op_hi == `IOMX_OP_HI_MOV) && (op_sub == `IOMX_SUB_OR);
  assign is_ptr    = (op_hi == `IOMX_OP_HI_LONG) && (instr_ff[11:8] == `IOMX_SUB_PTR);
  assign dest_file = instr_ff[`IOMX_BIT_D];
  assign inc_sum   = {1'b0, oper_ff} + 9'h001;
  assign ptr_sel_now = (instr_ff[5:4] > 2'd2) ? 2'd2 : instr_ff[5:4];

  // Handshake: a new word is taken only in the decode phase of an idle or ending cycle.
  assign phase        = phase_ff;
  assign exec_busy    = (state_ff != ST_IDLE);
  assign instr_taken  = instr_valid && (phase_ff == PH_DEC);
  assign skip_active  = (state_ff == ST_SKIP);
  assign working_register = working_register_ff;
  assign status_flags     = flags_ff;
  assign ptr0_ff_out = ptr_ff[0];
  assign ptr1_ff_out = ptr_ff[1];
  assign ptr2_ff_out = ptr_ff[2];

  // Result and flag computation for the process phase.
  always @* begin
    nxt_result = oper_ff;
    nxt_flags  = flags_ff;
    nxt_skip   = 1'b0;
    if (is_inc || is_insz || is_insnz) begin
      nxt_result = inc_sum[7:0];
    end else if (is_or) begin
      nxt_result = working_register_ff | oper_ff;
    end
    if (is_inc) begin
      nxt_flags[`IOMX_FLAG_C]  = inc_sum[8];
      nxt_flags[`IOMX_FLAG_DC] = (oper_ff[3:0] == 4'hF);
      nxt_flags[`IOMX_FLAG_OV] = (oper_ff == 8'h7F);
      nxt_flags[`IOMX_FLAG_N]  = inc_sum[7];
      nxt_flags[`IOMX_FLAG_Z]  = (inc_sum[7:0] == 8'h00);
    end else if (is_or || is_mov) begin
      // Carry, digit carry and overflow are kept untouched here.
      nxt_flags[`IOMX_FLAG_N] = nxt_result[7];
      nxt_flags[`IOMX_FLAG_Z] = (nxt_result == 8'h00);
    end
    // Skip forms keep all flags; only the skip decision is made.
    if (is_insz) begin
      nxt_skip = (inc_sum[7:0] == 8'h00);
    end else if (is_insnz) begin
      nxt_skip = (inc_sum[7:0] != 8'h00);
    end
  end

  // Phase counter: four phases make one instruction cycle.
  always @(posedge clk) begin
    if (!resetn) begin
      phase_ff <= PH_DEC;
    end else begin
      phase_ff <= phase_ff + 2'd1;
    end
  end

  // Sequencer, data path and register file writes.
  always @(posedge clk) begin
    if (!resetn) begin
      state_ff   <= ST_IDLE;
      instr_ff   <= 16'h0000;
      oper_ff    <= 8'h00;
      result_ff  <= 8'h00;
      working_register_ff    <= 8'h00;
      flags_ff   <= `IOMX_STATUS_RESET;
      ptr_hi_ff  <= 4'h0;
      ptr_sel_ff <= 2'd0;
      skip_ff    <= 1'b0;
      skip2_ff   <= 1'b0;
      file_addr  <= 12'h000;
      file_wdata <= 8'h00;
      file_we    <= 1'b0;
      ptr_ff[0]  <= {PTR_W{1'b0}};
      ptr_ff[1]  <= {PTR_W{1'b0}};
      ptr_ff[2]  <= {PTR_W{1'b0}};
    end else begin
      file_we <= 1'b0;
      case (phase_ff)
        PH_DEC: begin
          // A skipped word, and the second word of a skipped pair, run as no-operation.
          if (skip_ff) begin
            state_ff <= ST_SKIP;
            skip_ff  <= 1'b0;
            skip2_ff <= instr_valid && two_word;
            instr_ff <= 16'h0000;
          end else if (skip2_ff) begin
            state_ff <= ST_SKIP;
            skip2_ff <= 1'b0;
            instr_ff <= 16'h0000;
          end else if (state_ff == ST_PTRLO) begin
            state_ff <= ST_IDLE;
            if (instr_valid) begin
              ptr_ff[ptr_sel_ff] <= {ptr_hi_ff, instr_word[7:0]};
            end
          end else if (instr_valid) begin
            instr_ff <= instr_word;
            state_ff <= ST_EXEC;
            // Operand address from the access bank or the selected bank.
            if (instr_word[`IOMX_BIT_A]) begin
              file_addr <= {bank_select_register[3:0], instr_word[7:0]};
            end else begin
              file_addr <= {`IOMX_ACCESS_BANK, instr_word[7:0]};
            end
          end else begin
            state_ff <= ST_IDLE;
          end
        end
        PH_READ: begin
          oper_ff <= file_rdata;
        end
        PH_PROC: begin
          if (state_ff == ST_EXEC) begin
            result_ff <= nxt_result;
          end
        end
        default: begin
          if (state_ff == ST_EXEC) begin
            if (is_ptr) begin
              // High part lands in the first cycle, low byte waits for word two.
              ptr_ff[ptr_sel_now] <= {instr_ff[3:0], ptr_ff[ptr_sel_now][7:0]};
              ptr_hi_ff  <= instr_ff[3:0];
              ptr_sel_ff <= ptr_sel_now;
              state_ff   <= ST_PTRLO;
            end else if (is_inc || is_insz || is_insnz || is_or || is_mov) begin
              flags_ff <= nxt_flags;
              skip_ff  <= nxt_skip;
              if (dest_file) begin
                file_wdata <= result_ff;
                file_we    <= 1'b1;
              end else begin
                working_register_ff <= result_ff;
              end
              state_ff <= ST_IDLE;
            end else begin
              state_ff <= ST_IDLE;
            end
          end else if (state_ff == ST_SKIP) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule // iomx_execute

// ### testbench/iomx_assertions.sv
// Concurrent checks on the execute block, bound to its ports.
`timescale 1ns/1ps
module iomx_chk #(
  parameter PTR_W = 12
) (
  input wire             clk,
  input wire             resetn,
  input wire [15:0]      instr_word,
  input wire [7:0]       bank_select_register,
  input wire [7:0]       file_rdata,
  input wire [11:0]      file_addr,
  input wire             file_we,
  input wire [4:0]       status_flags,
  input wire [PTR_W-1:0] ptr1_ff_out,
  input wire [1:0]       phase,
  input wire             instr_taken,
  input wire             skip_active
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire [3:0] hi = instr_word[15:12];
  // A word offered at a decode edge. The skip flag only rises after that edge, so a
  // discarded word is told apart by the sampled skip flag one clock later.
  sequence s_go; instr_taken; endsequence
  sequence s_byte; s_go ##0 (hi >= 4'h1 && hi <= 4'h5); endsequence
  sequence s_skz; s_go ##0 (hi == 4'h3 || hi == 4'h4); endsequence
  property p_phase; 1'b1 |=> phase == $past(phase) + 2'd1; endproperty
  a_phase: assert property (p_phase) else $error("phase slip");
  property p_addr;
    s_byte ##1 !skip_active |-> file_addr[7:0] == $past(instr_word[7:0]) &&
      file_addr[11:8] == ($past(instr_word[8]) ? $past(bank_select_register[3:0]) : 4'h0);
  endproperty
  a_addr: assert property (p_addr) else $error("bad file address");
  property p_file; s_byte ##0 instr_word[9] ##1 !skip_active |-> ##3 file_we; endproperty
  a_file: assert property (p_file) else $error("no file write");
  property p_working_register; s_byte ##0 !instr_word[9] ##1 !skip_active |-> ##3 !file_we; endproperty
  a_working_register: assert property (p_working_register) else $error("file written");
  property p_keep; s_skz ##1 !skip_active |-> $stable(status_flags) [*4]; endproperty
  a_keep: assert property (p_keep) else $error("flags moved");
  property p_nz;
    s_go ##0 (hi == 4'h1 || hi == 4'h5) ##1 !skip_active |->
      ##3 (status_flags & 5'h0B) == ($past(status_flags, 4) & 5'h0B);
  endproperty
  a_nz: assert property (p_nz) else $error("carry flags moved");
  // The skip cycle starts at the decode edge after the write, so it is seen one clock later.
  property p_skz;
    s_go ##0 (hi == 4'h3 && instr_word[11:10] == 2'b11) ##1
      (!skip_active && file_rdata == 8'hFF) |-> ##4 skip_active;
  endproperty
  a_skz: assert property (p_skz) else $error("zero skip missed");
  property p_snz;
    s_go ##0 (hi == 4'h4 && instr_word[11:10] == 2'b10) ##1
      (!skip_active && file_rdata != 8'hFF) |-> ##4 skip_active;
  endproperty
  a_snz: assert property (p_snz) else $error("nonzero skip missed");
  property p_two; s_go ##0 (instr_word[15:8] == 8'hEE) ##1 skip_active |-> ##4 skip_active;
  endproperty
  a_two: assert property (p_two) else $error("short skip");
  property p_ptr;
    s_go ##0 (instr_word[15:8] == 8'hEE && instr_word[5:4] == 2'd1) ##1 !skip_active |->
      ##3 ptr1_ff_out[11:8] == $past(instr_word[3:0], 4);
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer high wrong");
endmodule // iomx_chk
bind iomx_execute iomx_chk #(.PTR_W(PTR_W)) u_chk (.clk, .resetn, .instr_word,
  .bank_select_register, .file_rdata, .file_addr, .file_we, .status_flags,
  .ptr1_ff_out, .phase, .instr_taken, .skip_active);

// ### testbench/tb.sv
// Directed test of the execute block.
`timescale 1ns/1ps
module tb;
  reg         clk, resetn, instr_valid, sk, bz;
  reg  [15:0] instr_word;
  reg  [7:0]  bank_select_register, file_rdata;
  reg  [11:0] ad;
  wire [11:0] file_addr, ptr0_ff_out, ptr1_ff_out, ptr2_ff_out;
  wire [7:0]  file_wdata, working_register;
  wire [4:0]  status_flags;
  wire [1:0]  phase;
  wire        file_we, instr_taken, skip_active, exec_busy;
  integer     bad_count, total_checks;
  iomx_execute #(.PTR_W(12)) uut (.clk, .resetn, .instr_valid, .instr_word,
    .bank_select_register, .file_rdata, .file_addr, .file_wdata, .file_we,
    .working_register, .status_flags, .ptr0_ff_out, .ptr1_ff_out, .ptr2_ff_out,
    .phase, .instr_taken, .skip_active, .exec_busy);
  // Free-running core clock.
  always #25 clk = ~clk;
  // Offer one word at a phase 0 edge and run its full four-phase cycle.
  task op(input [15:0] w, input [7:0] rd);
    begin
      instr_word = w;
      file_rdata = rd;
      @(negedge clk);
      sk = skip_active;
      bz = exec_busy;
      ad = file_addr;
      repeat (3) @(negedge clk);
    end
  endtask
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %s expected %h got %h", nm, e, g);
      end
    end
  endtask
  task finish_test;
    begin
      if (bad_count == 0 && total_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // A hang ends the run as a failure.
  initial begin
    #20000;
    bad_count = bad_count + 1;
    finish_test;
  end
  // Words follow back to back, so skips land on real fetched words.
  initial begin
    {clk, resetn, instr_valid} = 3'b000;
    {instr_word, file_rdata} = 24'h00_0000;
    bad_count = 0;
    total_checks = 0;
    bank_select_register = 8'h05;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    instr_valid = 1'b1;
    op(16'h2A3C, 8'hFF);
    chk("addr", 16'h003C, ad);
    chk("busy", 16'h0001, bz);
    chk("we", 16'h0001, file_we);
    chk("wdata", 16'h0000, file_wdata);
    chk("flags", 16'h0007, status_flags);
    op(16'h297F, 8'h7F);
    chk("addr", 16'h057F, ad);
    chk("we", 16'h0000, file_we);
    chk("working_register", 16'h0080, working_register);
    chk("flags", 16'h001A, status_flags);
    bank_select_register = 8'h0F;
    op(16'h51FF, 8'h00);
    chk("addr", 16'h0FFF, ad);
    chk("flags", 16'h000E, status_flags);
    op(16'h1020, 8'h91);
    chk("working_register", 16'h0091, working_register);
    chk("flags", 16'h001A, status_flags);
    op(16'h1220, 8'h06);
    chk("wdata", 16'h0097, file_wdata);
    op(16'h3C10, 8'hFF);
    chk("flags", 16'h001A, status_flags);
    op(16'h5010, 8'h55);
    chk("skip", 16'h0001, sk);
    chk("working_register", 16'h0000, working_register);
    op(16'h3C10, 8'h00);
    op(16'h4A30, 8'hFF);
    chk("skip", 16'h0000, sk);
    op(16'hEE1A, 8'h00);
    chk("skip", 16'h0000, sk);
    chk("ptr1 high", 16'h000A, ptr1_ff_out[11:8]);
    op(16'hF0BC, 8'h00);
    chk("ptr1", 16'h0ABC, ptr1_ff_out);
    chk("busy", 16'h0000, bz);
    op(16'h4A30, 8'h10);
    chk("wdata", 16'h0011, file_wdata);
    op(16'hEE2A, 8'h00);
    chk("skip", 16'h0001, sk);
    op(16'hF0BC, 8'h00);
    chk("skip", 16'h0001, sk);
    chk("ptr2", 16'h0000, ptr2_ff_out);
    op(16'hEE05, 8'h00);
    op(16'hF0FF, 8'h00);
    chk("ptr0", 16'h05FF, ptr0_ff_out);
    chk("flags", 16'h001A, status_flags);
    finish_test;
  end
endmodule // tb
